// file: acif_defs.svh
`ifndef ACIF_DEFS_SVH
`define ACIF_DEFS_SVH
// Configuration word indices.
`define ACIF_IDX_GAIN 4'h0
`define ACIF_IDX_DCB 4'h9
`define ACIF_NUM_WORDS 10
// Coefficient format.
`define ACIF_COEF_W 12
`define ACIF_FRAC_BITS 9
`define ACIF_ONE 12'h200
`define ACIF_SAMP_W 16
`define ACIF_ACC_W 40
// Input gain threshold in 3dB steps of the combined analogue gain code; 24dB is code 8.
`define ACIF_LINE_THRESH 4'h8
`define ACIF_FIRST_STAGE_STEPS 4'h8
`define ACIF_FIFO_DEPTH 16
// Side-tone gain shift range.
`define ACIF_ST_GAIN_W 4
`endif

// file: acif_pkg.sv
`default_nettype none
package acif_pkg;
	typedef enum logic [2:0] {
		ACIF_IDLE,
		ACIF_S1,
		ACIF_S2,
		ACIF_GAIN,
		ACIF_DCB,
		ACIF_OUT
	} acif_state_t;
endpackage : acif_pkg
`default_nettype wire

// file: acif_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module acif_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic [AW:0] cnt_next;
	logic ready_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	// Ready is registered so that the upstream side sees a flip-flop, not a compare.
	assign in_ready = ready_reg;
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_next;
			ready_reg <= (cnt_next < (AW+1)'(DEPTH));
		end
	end
endmodule : acif_fifo
`default_nettype wire

// file: acif_mac.sv
`timescale 1ns/1ns
`default_nettype none
`include "acif_defs.svh"
// One biquad section in direct form I, computed in a single cycle.
module acif_mac #(
	parameter int SW = 16
) (
	input wire logic signed [SW-1:0] x0,
	input wire logic signed [SW-1:0] x1,
	input wire logic signed [SW-1:0] x2,
	input wire logic signed [SW-1:0] y1,
	input wire logic signed [SW-1:0] y2,
	input wire logic signed [11:0] b1,
	input wire logic signed [11:0] b2,
	input wire logic signed [11:0] a1,
	input wire logic signed [11:0] a2,
	output logic signed [SW-1:0] y0
);
	logic signed [39:0] acc;
	logic signed [39:0] shf;
	// Unit leading coefficients; the feedback terms subtract.
	assign acc = (40'(x0) <<< `ACIF_FRAC_BITS) + 40'(x1 * b1) + 40'(x2 * b2)
		- 40'(y1 * a1) - 40'(y2 * a2);
	assign shf = acc >>> `ACIF_FRAC_BITS;
	// Saturate instead of wrapping.
	assign y0 = (shf > 40'(2**(SW-1)-1)) ? SW'(2**(SW-1)-1)
		: (shf < -40'(2**(SW-1))) ? SW'(-(2**(SW-1))) : shf[SW-1:0];
endmodule : acif_mac
`default_nettype wire

// file: acif_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "acif_defs.svh"
// Overview of operation
// - Record samples pass through two cascaded biquad sections in the ADC path.
// - Ten configuration words: gain, eight coefficients, DC-block switch.
// - Gain and coefficients are 12-bit signed, binary point between bits 9 and 8.
// - Pattern 0x200 is plus one, 0x400 is plus two.
// - Word index: 0 gain, 1-4 section one, 5-8 section two, 9 DC block.
// - Response is gain times two biquads with unit leading terms.
// - DC-block word set applies one minus z^-1 after the filter.
// - Channel A and B are configured, enabled and disabled separately.
// - Input gain below 24dB selects line mode and powers down stage one.
// - Playback 16-bit samples become a bit stream for the output.
// - Three-bit output gain code selects a divider setting.
// - Four-bit bias voltage code passes to the bias regulator.
// - Four-bit bias current code passes to the bias regulator.
// - Bias output has an enable control.
// - Channel 0 is the standard mono channel, channel 1 the auxiliary.
// - Side tone adds attenuated microphone copy to the earpiece output.
// - Stage one bypassed or 24dB; stage two up to seven 3dB steps.
// - Output gain code 7 is +3dB down to code 0 at -18dB.
module acif_top #(
	parameter int SW = `ACIF_SAMP_W,
	parameter int DEPTH = `ACIF_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cfg_we,
	input wire logic cfg_chan,
	input wire logic [3:0] cfg_index,
	input wire logic [11:0] cfg_data,
	input wire logic filt_en_a,
	input wire logic filt_en_b,
	input wire logic chan_en_a,
	input wire logic chan_en_b,
	input wire logic [SW-1:0] adc_data,
	input wire logic adc_chan,
	input wire logic adc_valid,
	output logic adc_ready,
	output logic [SW-1:0] rec_data,
	output logic rec_chan,
	output logic rec_valid,
	input wire logic rec_ready,
	input wire logic mic_mode,
	input wire logic [2:0] in_gain_step,
	output logic line_mode,
	output logic stage1_pd,
	output logic [2:0] stage2_gain,
	input wire logic [SW-1:0] play_data,
	input wire logic play_valid,
	output logic play_bit,
	input wire logic [2:0] out_gain_code,
	output logic [2:0] out_divider,
	input wire logic [3:0] bias_voltage_code,
	input wire logic [3:0] bias_current_code,
	input wire logic bias_enable,
	output logic [3:0] bias_voltage_level,
	output logic [3:0] bias_current_level,
	output logic microphone_bias_output,
	input wire logic sidetone_on_setting,
	input wire logic [3:0] sidetone_gain_setting,
	input wire logic sidetone_tap_after_adc,
	input wire logic sidetone_tap_after_dac,
	output logic [SW-1:0] earpiece_data,
	output logic chan_pd_a,
	output logic chan_pd_b
);
	// Ten-word configuration per channel.
	logic signed [11:0] cfg_a [`ACIF_NUM_WORDS];
	logic signed [11:0] cfg_b [`ACIF_NUM_WORDS];
	// Biquad history per channel: x1,x2,y1,y2 for two sections, plus DC-block memory.
	logic signed [SW-1:0] hist_a [9];
	logic signed [SW-1:0] hist_b [9];
	acif_pkg::acif_state_t state_reg;
	logic [SW-1:0] fifo_data;
	logic fifo_chan;
	logic fifo_valid;
	logic fifo_ready;
	logic [SW:0] fifo_word;
	logic [SW-1:0] raw_reg;
	logic signed [SW-1:0] out_reg;
	logic chan_reg;
	logic signed [SW-1:0] s1_reg;
	logic signed [SW-1:0] s2_reg;
	logic signed [SW-1:0] g_reg;

	acif_fifo #(.WIDTH(SW+1), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_data({adc_chan, adc_data}),
		.in_valid(adc_valid),
		.in_ready(adc_ready),
		.out_data(fifo_word),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready)
	);
	assign fifo_data = fifo_word[SW-1:0];
	assign fifo_chan = fifo_word[SW];

	function automatic logic signed [SW-1:0] sat(input logic signed [39:0] v);
		if (v > 40'(2**(SW-1)-1)) begin
			sat = SW'(2**(SW-1)-1);
		end else if (v < -40'(2**(SW-1))) begin
			sat = SW'(-(2**(SW-1)));
		end else begin
			sat = v[SW-1:0];
		end
	endfunction : sat

	// Per-sample selection of the active channel's words and history.
	wire ch = chan_reg;
	wire signed [11:0] w_gain = ch ? cfg_b[`ACIF_IDX_GAIN] : cfg_a[`ACIF_IDX_GAIN];
	wire signed [11:0] c01 = ch ? cfg_b[1] : cfg_a[1];
	wire signed [11:0] c02 = ch ? cfg_b[2] : cfg_a[2];
	wire signed [11:0] c03 = ch ? cfg_b[3] : cfg_a[3];
	wire signed [11:0] c04 = ch ? cfg_b[4] : cfg_a[4];
	wire signed [11:0] c11 = ch ? cfg_b[5] : cfg_a[5];
	wire signed [11:0] c12 = ch ? cfg_b[6] : cfg_a[6];
	wire signed [11:0] c13 = ch ? cfg_b[7] : cfg_a[7];
	wire signed [11:0] c14 = ch ? cfg_b[8] : cfg_a[8];
	wire dcb_on = ch ? cfg_b[`ACIF_IDX_DCB][0] : cfg_a[`ACIF_IDX_DCB][0];
	wire filt_on = ch ? filt_en_b : filt_en_a;
	wire signed [SW-1:0] h0 = ch ? hist_b[0] : hist_a[0];
	wire signed [SW-1:0] h1 = ch ? hist_b[1] : hist_a[1];
	wire signed [SW-1:0] h2 = ch ? hist_b[2] : hist_a[2];
	wire signed [SW-1:0] h3 = ch ? hist_b[3] : hist_a[3];
	wire signed [SW-1:0] h4 = ch ? hist_b[4] : hist_a[4];
	wire signed [SW-1:0] h5 = ch ? hist_b[5] : hist_a[5];
	wire signed [SW-1:0] h6 = ch ? hist_b[6] : hist_a[6];
	wire signed [SW-1:0] h7 = ch ? hist_b[7] : hist_a[7];
	wire signed [SW-1:0] h8 = ch ? hist_b[8] : hist_a[8];
	logic signed [SW-1:0] sec1_y;
	logic signed [SW-1:0] sec2_y;

	// Section one, then section two fed by the registered first result.
	acif_mac #(.SW(SW)) u_sec1 (
		.x0(raw_reg), .x1(h0), .x2(h1), .y1(h2), .y2(h3),
		.b1(c01), .b2(c02), .a1(c03), .a2(c04), .y0(sec1_y)
	);
	acif_mac #(.SW(SW)) u_sec2 (
		.x0(s1_reg), .x1(h4), .x2(h5), .y1(h6), .y2(h7),
		.b1(c11), .b2(c12), .a1(c13), .a2(c14), .y0(sec2_y)
	);

	// Gain in Q2.9 and the optional first difference.
	wire signed [39:0] gain_prod = 40'(s2_reg * w_gain) >>> `ACIF_FRAC_BITS;
	wire signed [39:0] dc_diff = 40'(g_reg) - 40'(h8);

	assign fifo_ready = (state_reg == acif_pkg::ACIF_IDLE);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `ACIF_NUM_WORDS; i++) begin
				cfg_a[i] <= '0;
				cfg_b[i] <= '0;
			end
			cfg_a[`ACIF_IDX_GAIN] <= `ACIF_ONE;
			cfg_b[`ACIF_IDX_GAIN] <= `ACIF_ONE;
		end else if (cfg_we && (cfg_index < 4'(`ACIF_NUM_WORDS))) begin
			if (cfg_chan) begin
				cfg_b[cfg_index] <= cfg_data;
			end else begin
				cfg_a[cfg_index] <= cfg_data;
			end
		end
	end

	// One sample per pass: load, section one, section two, gain, DC block, output.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= acif_pkg::ACIF_IDLE;
			raw_reg <= '0;
			chan_reg <= 1'b0;
			s1_reg <= '0;
			s2_reg <= '0;
			g_reg <= '0;
			out_reg <= '0;
			rec_data <= '0;
			rec_chan <= 1'b0;
			rec_valid <= 1'b0;
			for (int i = 0; i < 9; i++) begin
				hist_a[i] <= '0;
				hist_b[i] <= '0;
			end
		end else begin
			if (rec_valid && rec_ready) begin
				rec_valid <= 1'b0;
			end
			unique case (state_reg)
				acif_pkg::ACIF_IDLE: begin
					if (fifo_valid) begin
						raw_reg <= fifo_data;
						chan_reg <= fifo_chan;
						state_reg <= acif_pkg::ACIF_S1;
					end
				end
				acif_pkg::ACIF_S1: begin
					s1_reg <= sec1_y;
					state_reg <= acif_pkg::ACIF_S2;
				end
				acif_pkg::ACIF_S2: begin
					s2_reg <= sec2_y;
					state_reg <= acif_pkg::ACIF_GAIN;
				end
				acif_pkg::ACIF_GAIN: begin
					g_reg <= sat(gain_prod);
					state_reg <= acif_pkg::ACIF_DCB;
				end
				acif_pkg::ACIF_DCB: begin
					out_reg <= !filt_on ? raw_reg : (dcb_on ? sat(dc_diff) : g_reg);
					if (filt_on) begin
						if (ch) begin
							hist_b <= '{raw_reg, h0, s1_reg, h2, s1_reg, h4, s2_reg, h6, g_reg};
						end else begin
							hist_a <= '{raw_reg, h0, s1_reg, h2, s1_reg, h4, s2_reg, h6, g_reg};
						end
					end
					state_reg <= acif_pkg::ACIF_OUT;
				end
				acif_pkg::ACIF_OUT: begin
					if (!rec_valid || rec_ready) begin
						rec_data <= out_reg;
						rec_chan <= chan_reg;
						rec_valid <= 1'b1;
						state_reg <= acif_pkg::ACIF_IDLE;
					end
				end
			endcase
		end
	end

	// Analogue gain split: microphone mode adds the 24dB first stage.
	wire [3:0] total_step = (mic_mode ? `ACIF_FIRST_STAGE_STEPS : 4'h0) + {1'b0, in_gain_step};
	wire line_sel = (total_step < `ACIF_LINE_THRESH);

	// Playback first-order sigma-delta modulator.
	logic signed [SW+1:0] sd_reg;
	wire signed [SW+1:0] sd_fb = play_bit ? (SW+2)'(2**(SW-1)) : -(SW+2)'(2**(SW-1));
	wire signed [SW+1:0] sd_next = sd_reg + (SW+2)'(signed'(play_data)) - sd_fb;

	// Side tone: attenuated microphone copy taken before or after filtering.
	wire signed [SW-1:0] st_src = sidetone_tap_after_adc ? out_reg : raw_reg;
	wire signed [SW-1:0] st_att = st_src >>> sidetone_gain_setting;
	wire signed [SW-1:0] st_base = sidetone_tap_after_dac ? SW'(play_data) : '0;
	wire signed [39:0] st_sum = 40'(st_base) + (sidetone_on_setting ? 40'(st_att) : 40'(0));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			line_mode <= 1'b1;
			stage1_pd <= 1'b1;
			stage2_gain <= '0;
			sd_reg <= '0;
			play_bit <= 1'b0;
			out_divider <= '0;
			bias_voltage_level <= '0;
			bias_current_level <= '0;
			microphone_bias_output <= 1'b0;
			earpiece_data <= '0;
			chan_pd_a <= 1'b1;
			chan_pd_b <= 1'b1;
		end else begin
			line_mode <= line_sel;
			stage1_pd <= line_sel;
			stage2_gain <= in_gain_step;
			if (play_valid) begin
				sd_reg <= sd_next;
				play_bit <= !sd_next[SW+1];
			end
			out_divider <= out_gain_code;
			bias_voltage_level <= bias_voltage_code;
			bias_current_level <= bias_current_code;
			microphone_bias_output <= bias_enable;
			earpiece_data <= sat(st_sum);
			chan_pd_a <= !chan_en_a;
			chan_pd_b <= !chan_en_b;
		end
	end

	property p_line_mode;
		@(posedge clk) disable iff (!resetn)
		(!mic_mode) |=> line_mode && stage1_pd;
	endproperty
	a_line_mode: assert property (p_line_mode) else $error("line mode not set");

	property p_mic_mode;
		@(posedge clk) disable iff (!resetn)
		mic_mode |=> !line_mode;
	endproperty
	a_mic_mode: assert property (p_mic_mode) else $error("mic mode lost");

	sequence s_take;
		state_reg == acif_pkg::ACIF_IDLE && fifo_valid;
	endsequence
	property p_pass;
		@(posedge clk) disable iff (!resetn)
		s_take |-> ##5 (state_reg == acif_pkg::ACIF_OUT);
	endproperty
	a_pass: assert property (p_pass) else $error("sample pass wrong length");

	property p_bypass;
		@(posedge clk) disable iff (!resetn)
		(state_reg == acif_pkg::ACIF_DCB && !filt_on) |=> out_reg == $past(raw_reg);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass altered sample");

	property p_dcb;
		@(posedge clk) disable iff (!resetn)
		(state_reg == acif_pkg::ACIF_DCB && filt_on && !dcb_on) |=> out_reg == $past(g_reg);
	endproperty
	a_dcb: assert property (p_dcb) else $error("dc block not bypassed");

	property p_bias;
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> microphone_bias_output == $past(bias_enable)
			&& bias_voltage_level == $past(bias_voltage_code);
	endproperty
	a_bias: assert property (p_bias) else $error("bias settings not applied");

	property p_cur;
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> bias_current_level == $past(bias_current_code);
	endproperty
	a_cur: assert property (p_cur) else $error("bias current not applied");

	property p_out_gain;
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> out_divider == $past(out_gain_code);
	endproperty
	a_out_gain: assert property (p_out_gain) else $error("output gain not applied");
endmodule : acif_top
`default_nettype wire

// file: tb_audio_codec_iir_filter_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_audio_codec_iir_filter_ctrl;
	logic clk = 1'b0, resetn = 1'b0, cfg_we = 1'b0, cfg_chan = 1'b0, filt_en_a = 1'b0;
	logic filt_en_b = 1'b0, chan_en_a = 1'b0, chan_en_b = 1'b0, adc_chan = 1'b0, adc_valid = 1'b0;
	logic rec_ready = 1'b0, mic_mode = 1'b0, play_valid = 1'b0, bias_enable = 1'b0;
	logic sidetone_on_setting = 1'b0, sidetone_tap_after_adc = 1'b0, sidetone_tap_after_dac = 1'b0;
	logic [3:0] cfg_index = 4'h0, bias_voltage_code = 4'h0, bias_current_code = 4'h0;
	logic [3:0] sidetone_gain_setting = 4'h0, bias_voltage_level, bias_current_level;
	logic [11:0] cfg_data = 12'h000;
	logic [15:0] adc_data = 16'h0000, play_data = 16'h0000, rec_data, earpiece_data;
	logic [2:0] in_gain_step = 3'h0, out_gain_code = 3'h0, stage2_gain, out_divider;
	logic adc_ready, rec_chan, rec_valid, line_mode, stage1_pd, play_bit;
	logic microphone_bias_output, chan_pd_a, chan_pd_b;
	logic [31:0] seed = 32'h5793;
	logic [1:0] rmode = 2'h0;
	logic [16:0] expq[$], gotq[$];
	logic [15:0] last_in = 16'h0000, last_out = 16'h0000;
	int bad_count = 0, n_tests = 0;
	int k[2][10], x1[2], x2[2], p1[2], p2[2], q1[2], q2[2], r1[2], r2[2], dprev[2];
	acif_top u_acif_top (.clk, .resetn, .cfg_we, .cfg_chan, .cfg_index, .cfg_data, .filt_en_a,
		.filt_en_b, .chan_en_a, .chan_en_b, .adc_data, .adc_chan, .adc_valid, .adc_ready,
		.rec_data, .rec_chan, .rec_valid, .rec_ready, .mic_mode, .in_gain_step, .line_mode,
		.stage1_pd, .stage2_gain, .play_data, .play_valid, .play_bit, .out_gain_code,
		.out_divider, .bias_voltage_code, .bias_current_code, .bias_enable,
		.bias_voltage_level, .bias_current_level, .microphone_bias_output,
		.sidetone_on_setting, .sidetone_gain_setting, .sidetone_tap_after_adc,
		.sidetone_tap_after_dac, .earpiece_data, .chan_pd_a, .chan_pd_b);
	always #4 clk = ~clk;
	// Output handshake completes on the edge where both valid and ready are high.
	always @(posedge clk) if (rec_valid === 1'b1 && rec_ready === 1'b1) gotq.push_back({rec_chan, rec_data});
	always @(negedge clk) rec_ready <= rmode == 2'h2 || (rmode == 2'h1 && (rnd() & 32'h3) != 32'h0);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int sat(longint v);
		return v > 32767 ? 32767 : (v < -32768 ? -32768 : int'(v));
	endfunction : sat
	// Reference filter for coefficients restricted to whole numbers.
	function automatic int model(int c, int x, logic en);
		int s, t, g, o;
		if (en !== 1'b1) return x;
		s = sat(x + k[c][1] * x1[c] + k[c][2] * x2[c] - k[c][3] * p1[c] - k[c][4] * p2[c]);
		x2[c] = x1[c]; x1[c] = x; p2[c] = p1[c]; p1[c] = s;
		t = sat(s + k[c][5] * q1[c] + k[c][6] * q2[c] - k[c][7] * r1[c] - k[c][8] * r2[c]);
		q2[c] = q1[c]; q1[c] = s; r2[c] = r1[c]; r1[c] = t;
		g = sat(k[c][0] * t);
		o = k[c][9] != 0 ? sat(g - dprev[c]) : g;
		dprev[c] = g;
		return o;
	endfunction : model
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word
	task automatic check_flag(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask : check_flag
	task automatic do_reset(input int n);
		resetn = 1'b0;
		repeat (n) @(negedge clk);
		resetn = 1'b1;
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 10; i++) k[c][i] = i == 0 ? 1 : 0;
			x1[c] = 0; x2[c] = 0; p1[c] = 0; p2[c] = 0; q1[c] = 0; q2[c] = 0;
			r1[c] = 0; r2[c] = 0; dprev[c] = 0;
		end
	endtask : do_reset
	task automatic cfg(input logic c, input logic [3:0] i, input logic [11:0] w);
		cfg_we = 1'b1; cfg_chan = c; cfg_index = i; cfg_data = w;
		if (i <= 4'h9) k[c][i] = i == 4'h9 ? int'(w[0]) : $signed(w) / 512;
		@(negedge clk);
		cfg_we = 1'b0;
		@(negedge clk);
	endtask : cfg
	task automatic stream(input int n, input bit corner, input bit fill, output int acc);
		int w, lim;
		logic c;
		logic [15:0] d;
		logic [31:0] r;
		acc = 0;
		lim = fill ? 20 : 300;
		adc_valid = 1'b1;
		for (int i = 0; i < n; i++) begin
			r = rnd();
			c = corner && i < 2 ? i[0] : r[16];
			d = corner && i < 2 ? 16'h8000 : {{6{r[9]}}, r[9:0]};
			adc_chan = c; adc_data = d;
			for (w = 0; w < lim && adc_ready !== 1'b1; w++) @(negedge clk);
			if (w == lim) begin
				if (!fill) begin
					bad_count++;
					report_and_stop();
				end
				break;
			end
			@(posedge clk);
			last_in = d;
			last_out = 16'(model(c, $signed(d), c ? filt_en_b : filt_en_a));
			expq.push_back({c, last_out});
			acc++;
			@(negedge clk);
		end
		adc_valid = 1'b0;
	endtask : stream
	task automatic drain();
		logic [16:0] e, g;
		int w;
		for (w = 0; w < 3000 && gotq.size() < expq.size(); w++) @(negedge clk);
		if (w == 3000) begin
			bad_count++;
			report_and_stop();
		end
		repeat (20) @(negedge clk);
		check_word("rec_count", 16'(expq.size()), 16'(gotq.size()));
		while (expq.size() > 0 && gotq.size() > 0) begin
			e = expq.pop_front();
			g = gotq.pop_front();
			check_word("rec_data", e[15:0], g[15:0]);
			check_flag("rec_chan", e[16], g[16]);
		end
		expq.delete();
		gotq.delete();
	endtask : drain
	initial begin
		logic [31:0] r;
		int acc, ones;
		do_reset(16);
		check_flag("line_mode", 1'b1, line_mode);
		check_flag("stage1_pd", 1'b1, stage1_pd);
		check_flag("chan_pd_a", 1'b1, chan_pd_a);
		check_flag("microphone_bias_output", 1'b0, microphone_bias_output);
		check_flag("rec_valid", 1'b0, rec_valid);
		for (int i = 0; i < 20; i++) begin
			r = i == 0 ? 32'h0 : (i == 1 ? 32'hFFFFFFFF : rnd());
			mic_mode = r[0]; in_gain_step = r[3:1]; out_gain_code = r[6:4];
			bias_voltage_code = r[10:7]; bias_current_code = r[14:11]; bias_enable = r[15];
			chan_en_a = r[16]; chan_en_b = r[17]; sidetone_tap_after_dac = r[18];
			sidetone_tap_after_adc = r[19]; play_data = {r[31:20], r[3:0]};
			repeat (2) @(negedge clk);
			check_flag("line_mode", ({1'b0, r[3:1]} + (r[0] ? 4'h8 : 4'h0)) < 4'h8, line_mode);
			check_flag("stage1_pd", !r[0], stage1_pd);
			check_word("stage2_gain", 16'(r[3:1]), 16'(stage2_gain));
			check_word("out_divider", 16'(r[6:4]), 16'(out_divider));
			check_word("bias_voltage_level", 16'(r[10:7]), 16'(bias_voltage_level));
			check_word("bias_current_level", 16'(r[14:11]), 16'(bias_current_level));
			check_flag("microphone_bias_output", r[15], microphone_bias_output);
			check_flag("chan_pd_a", !r[16], chan_pd_a);
			check_flag("chan_pd_b", !r[17], chan_pd_b);
			check_word("earpiece_data", r[18] ? play_data : 16'h0000, earpiece_data);
		end
		play_valid = 1'b1;
		for (int j = 0; j < 2; j++) begin
			play_data = j ? 16'hA000 : 16'h6000;
			ones = 0;
			repeat (16) @(negedge clk);
			repeat (64) begin
				@(negedge clk);
				ones += play_bit;
			end
			check_flag("play_bit_density", 1'b1, j ? ones <= 24 : ones >= 40);
		end
		do_reset(2);
		chan_en_a = 1'b1; chan_en_b = 1'b1; filt_en_a = 1'b1; filt_en_b = 1'b1;
		cfg(1'b0, 4'h1, 12'h200);
		cfg(1'b0, 4'h7, 12'h200);
		cfg(1'b0, 4'hC, 12'hE00);
		cfg(1'b1, 4'h0, 12'hE00);
		cfg(1'b1, 4'h2, 12'hE00);
		cfg(1'b1, 4'h6, 12'h200);
		cfg(1'b1, 4'h9, 12'h001);
		rmode = 2'h1;
		stream(30, 1'b0, 1'b0, acc);
		drain();
		// Side tone from the last raw and last filtered sample, over a fixed playback word.
		sidetone_on_setting = 1'b1; sidetone_gain_setting = 4'h2; sidetone_tap_after_dac = 1'b1;
		play_data = 16'h0100;
		for (int t = 0; t < 2; t++) begin
			sidetone_tap_after_adc = t[0];
			repeat (2) @(negedge clk);
			check_word("earpiece_sidetone", 16'(sat(256 + ($signed(t ? last_out : last_in) >>> 2))), earpiece_data);
		end
		sidetone_on_setting = 1'b0;
		do_reset(2);
		// Channel B is switched off and left unfiltered while its samples still stream; only channel A is filtered.
		filt_en_b = 1'b0; chan_en_b = 1'b0;
		cfg(1'b0, 4'h0, 12'hE00);
		rmode = 2'h0;
		@(negedge clk);
		stream(40, 1'b1, 1'b1, acc);
		check_flag("adc_refused", 1'b1, acc >= 16 && acc <= 18);
		check_flag("adc_ready", 1'b0, adc_ready);
		rmode = 2'h1;
		drain();
		report_and_stop();
	end
endmodule : tb_audio_codec_iir_filter_ctrl
`default_nettype wire
